// ===== inc/ddq_pkg.sv
// Purpose: Shared constants for the quadrature decimation and down-converter control block
// Assumes: APB with 32-bit data, byte registers in the low bits of each word
// Notes: Register constants are word indices; the byte address is four times the index
package ddq_pkg;
   // Register word indices, one aligned 32-bit word each
   localparam logic [7:0] DDQ_QDEC_ADDR = 8'h7C;
   localparam logic [7:0] DDQ_CTLA_ADDR = 8'h80;
   localparam logic [7:0] DDQ_CTLB_ADDR = 8'h81;
   localparam logic [7:0] DDQ_STAT_ADDR = 8'h98;
   // Reset values
   localparam logic [7:0] DDQ_QDEC_RST = 8'h00;
   localparam logic [7:0] DDQ_CTLA_RST = 8'h00;
   localparam logic [7:0] DDQ_CTLB_RST = 8'h00;
   // Control A fields
   localparam int DDQ_A_DDC1 = 0;
   localparam int DDQ_A_FS8 = 1;
   localparam int DDQ_A_LFSR = 2;
   localparam int DDQ_A_PHSD = 3;
   localparam int DDQ_A_AMPD = 4;
   localparam int DDQ_A_OSC = 5;
   localparam int DDQ_A_HBSEL = 6;
   // Control B fields
   localparam int DDQ_B_DDC2 = 6;
   localparam int DDQ_B_GAIN = 5;
   // Sizes
   localparam int DDQ_SW = 16;
   localparam int DDQ_NSTG = 8;
   localparam int DDQ_FIFO_DEPTH = 8;
   localparam int DDQ_CNTW = 8;
   localparam logic [DDQ_CNTW-1:0] DDQ_CNT_ONE = 8'h01;
   localparam logic [31:0] DDQ_ZERO32 = 32'h0000_0000;
   // Low address bits of an aligned word
   localparam logic [1:0] DDQ_BYTE_LANE = 2'h0;
   // Datapath states
   typedef enum logic [1:0] {
      DDQ_IDLE = 2'b01,
      DDQ_RUN = 2'b10
   } ddq_state_t;
endpackage

// ===== sim/ddq_ctrl_monitor.sv
// Purpose: Port assertions for the decimation control block
// Assumes: A write reaches the control outputs one cycle after pready
// Notes: Bound to every ddq_ctrl instance
`timescale 1ns/100ps
`default_nettype none
module ddq_ctrl_monitor
   import ddq_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_ce,
   input wire logic i_pwrite,
   input wire logic [9:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   input wire logic o_first_downconverter_enable,
   input wire logic o_second_downconverter_enable,
   input wire logic o_oscillator_enable,
   input wire logic o_dither_generator_enable,
   input wire logic o_eighth_rate_centering_enable,
   input wire logic o_halfband_response_select,
   input wire logic o_halfband_gain_select,
   input wire logic [3:0] o_quad_stage_count
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);
   // Completed writes and the down-conversion mode seen at the pins
   wire logic wr_done = o_pready && i_ce && i_pwrite;
   wire logic wr_a = wr_done && i_paddr == {DDQ_CTLA_ADDR, DDQ_BYTE_LANE};
   wire logic wr_b = wr_done && i_paddr == {DDQ_CTLB_ADDR, DDQ_BYTE_LANE};
   wire logic wr_q = wr_done && i_paddr == {DDQ_QDEC_ADDR, DDQ_BYTE_LANE};
   wire logic mode = o_first_downconverter_enable && o_dither_generator_enable
      && o_oscillator_enable;
   ////////////////////////////////////////////////////////////////////////////
   // Seven halving stages give the overall rate of 128
   chk_stage_full: assert property (wr_q && i_pwdata[7:0] == 8'hFF && mode
      |=> o_quad_stage_count == 4'h7) else $error("full pattern not seven stages");
   chk_stage_mode: assert property (o_quad_stage_count != 4'h0 |-> mode)
      else $error("stages active outside down-conversion");
   chk_stage_three: assert property (wr_q && i_pwdata[7:0] == 8'h03 && mode
      |=> o_quad_stage_count == 4'h1) else $error("pattern 03 not one stage");
   chk_stage_none: assert property (wr_q && i_pwdata[7:0] == 8'h01
      |=> o_quad_stage_count == 4'h0) else $error("pattern 01 enabled a stage");
   chk_second_conv: assert property (wr_b |=>
      o_second_downconverter_enable == $past(i_pwdata[6])) else $error("second enable");
   chk_gain_follow: assert property (wr_b |=>
      o_halfband_gain_select == $past(i_pwdata[5])) else $error("gain select");
   chk_resp_follow: assert property (wr_a |=>
      o_halfband_response_select == $past(i_pwdata[6])) else $error("response select");
   chk_eighth_follow: assert property (wr_a |=>
      o_eighth_rate_centering_enable == $past(i_pwdata[1])) else $error("eighth rate");
endmodule // ddq_ctrl_monitor
bind ddq_ctrl ddq_ctrl_monitor u_monitor (.*);
`default_nettype wire

// ===== sim/ddq_ctrl_test.sv
// Purpose: Self-checking bench for the decimation control block
// Assumes: Status word at 0x98 holds stages, mode, full and nonempty
// Notes: Expected reads and samples are queued by the drivers
`timescale 1ns/100ps
`default_nettype none
module ddq_ctrl_test;
   import ddq_pkg::*;
   logic i_mclk = 1'b0, i_reset_n = 1'b0, i_ce = 1'b1, go = 1'b0, hold = 1'b0;
   logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [9:0] i_paddr = '0;
   logic [7:0] cnt = '0;
   logic [31:0] i_pwdata = '0, o_prdata;
   logic o_pready, o_pslverr, i_q_valid, o_q_ready, o_out_valid, i_out_ready;
   logic [DDQ_SW-1:0] i_q_data, o_out_data;
   logic [3:0] o_quad_stage_count;
   wire logic o_first_downconverter_enable, o_second_downconverter_enable, o_oscillator_enable;
   wire logic o_dither_generator_enable, o_amplitude_dither_enable, o_phase_dither_enable;
   wire logic o_eighth_rate_centering_enable, o_halfband_response_select;
   wire logic o_halfband_gain_select;
   int bad_count = 0, samples_checked = 0;
   logic [32:0] rq[$];
   logic [DDQ_SW-1:0] sq[$];
   always #2.5 i_mclk = ~i_mclk;
   ddq_ctrl dut (.*);
   ddq_stream_partner u_partner (.i_mclk(i_mclk), .i_go(go), .i_hold(hold), .i_count(cnt),
      .i_q_ready(o_q_ready), .o_q_valid(i_q_valid), .o_q_data(i_q_data),
      .o_out_ready(i_out_ready));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Oldest note is compared whenever a result shows up
   always @(posedge i_mclk) begin
      if (o_pready && !i_pwrite) check("read", {o_pslverr, o_prdata}, rq.pop_front());
      if (o_out_valid && i_out_ready) check("sample", {17'h0, o_out_data},
         {17'h0, sq.pop_front()});
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      i_psel <= 1'b1; i_pwrite <= w; i_paddr <= {a, DDQ_BYTE_LANE}; i_pwdata <= d;
      @(posedge i_mclk) i_penable <= 1'b1;
      n = 0;
      do @(posedge i_mclk); while (o_pready !== 1'b1 && ++n < 40);
      i_psel <= 1'b0; i_penable <= 1'b0;
      if (n >= 40) bad_count++;
      @(posedge i_mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      rq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic reset_dut();
      i_reset_n <= 1'b0;
      repeat (5) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      @(posedge i_mclk);
   endtask
   // Contiguous ones from bit 0, less one; bit 0 alone enables nothing
   function automatic logic [3:0] stages(input logic [7:0] v);
      logic [3:0] n;
      n = '0;
      for (int i = 0; i < 8 && v[i]; i++) n++;
      return (n == 4'h0) ? 4'h0 : n - 4'h1;
   endfunction
   task automatic stream(input int num, input int step);
      int n;
      for (int i = 0; i < num; i += step) sq.push_back(DDQ_SW'(i));
      cnt <= 8'(num); go <= 1'b1;
      for (n = 0; n < 3000 && sq.size() != 0; n++) @(posedge i_mclk);
      if (sq.size() != 0) bad_count++;
   endtask
   task automatic conclude();
      $display("compared %0d, mismatched %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #50us bad_count++;
      conclude();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] r;
      logic [7:0] pats[10];
      int n;
      r = 8'($urandom(52));
      pats = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F, 8'h7F, 8'hFF, 8'h05};
      reset_dut();
      rd(DDQ_QDEC_ADDR, 33'h0);
      rd(DDQ_CTLA_ADDR, 33'h0);
      rd(DDQ_CTLB_ADDR, 33'h0);
      rd(8'h10, {1'b1, 32'h0});
      // Random settings with factory bits kept at zero
      r = 8'($urandom) & 8'h7F;
      wr(DDQ_CTLA_ADDR, r);
      rd(DDQ_CTLA_ADDR, {25'h0, r});
      check("ctla pins", {26'h0, o_halfband_response_select, o_oscillator_enable,
         o_amplitude_dither_enable, o_phase_dither_enable, o_dither_generator_enable,
         o_eighth_rate_centering_enable, o_first_downconverter_enable}, {26'h0, r[6:0]});
      r = 8'($urandom) & 8'h60;
      wr(DDQ_CTLB_ADDR, r);
      rd(DDQ_CTLB_ADDR, {25'h0, r});
      check("ctlb pins", {31'h0, o_second_downconverter_enable,
         o_halfband_gain_select}, {31'h0, r[6:5]});
      wr(DDQ_CTLA_ADDR, 8'h25);
      pats[9] = 8'($urandom);
      foreach (pats[i]) begin
         wr(DDQ_QDEC_ADDR, pats[i]);
         rd(DDQ_QDEC_ADDR, {25'h0, pats[i]});
         rd(DDQ_STAT_ADDR, {26'h1, 3'h0, stages(pats[i])});
         check("stage pins", {29'h0, o_quad_stage_count}, {29'h0, stages(pats[i])});
      end
      // Rate eight with the sink held until the buffer refuses
      reset_dut();
      wr(DDQ_CTLA_ADDR, 8'h25);
      wr(DDQ_QDEC_ADDR, 8'h0F);
      hold <= 1'b1;
      fork
         stream(80, 8);
         begin
            for (n = 0; n < 800 && !(i_q_valid && !o_q_ready); n++) @(posedge i_mclk);
            rd(DDQ_STAT_ADDR, 33'h383);
            hold <= 1'b0;
         end
      join
      rd(DDQ_STAT_ADDR, 33'h083);
      go <= 1'b0;
      // Third reset; outside down-conversion nothing is dropped
      reset_dut();
      rd(DDQ_QDEC_ADDR, 33'h0);
      wr(DDQ_QDEC_ADDR, 8'h07);
      rd(DDQ_STAT_ADDR, 33'h0);
      stream(16, 1);
      conclude();
   end
endmodule // ddq_ctrl_test
`default_nettype wire

// ===== sim/ddq_stream_partner.sv
// Purpose: Sample source and stalling sink around the block
// Assumes: Samples carry their own index as data
// Notes: Idle data toggles so a stale word is never mistaken for a sample
`timescale 1ns/100ps
`default_nettype none
module ddq_stream_partner
   import ddq_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_go,
   input wire logic i_hold,
   input wire logic [7:0] i_count,
   input wire logic i_q_ready,
   output logic o_q_valid,
   output logic [DDQ_SW-1:0] o_q_data,
   output logic o_out_ready
);
   logic [DDQ_SW-1:0] sent_r;
   logic [DDQ_SW-1:0] nxt;
   logic v;
   initial begin
      o_q_valid = 1'b0;
      o_q_data = '0;
      o_out_ready = 1'b0;
      sent_r = '0;
   end
   // Sample held until taken; sink stalls at random or on request
   always @(posedge i_mclk) begin
      nxt = sent_r + DDQ_SW'(o_q_valid && i_q_ready);
      v = i_go && nxt < {8'h00, i_count} && ($urandom % 2 == 1);
      o_out_ready <= !i_hold && ($urandom % 4 != 0);
      if (!i_go || !o_q_valid || i_q_ready) begin
         sent_r <= i_go ? nxt : '0;
         o_q_valid <= v;
         o_q_data <= v ? nxt : ~o_q_data;
      end
   end
endmodule // ddq_stream_partner
`default_nettype wire

// ===== verilog/ddq_ctrl.sv
// Purpose: Register file and quadrature decimation control for the down-converter path
// Assumes: APB slave, one clock, samples arrive with valid/ready
// Notes: Quadrature samples are decimated by dropping, not filtered here
//
// Notes on behaviour
// [RL1] Decimation field is thermometer coded; all eight bits set gives 128.
// [RL2] Decimation field acts only on quadrature data in down-conversion mode.
// [RL3] Pattern 0000-0011 enables stage three only, rate two.
// [RL4] Pattern 0000-0001 enables no stage and changes nothing.
// [RL5] Decimation field resets to zero, all stages bypassed.
// [RL6] Host keeps factory bits at their reset values.
// [RL7] Host sets converter, dither generator and oscillator enables together.
// [RL8] Control B bit 6 enables second converter; resets disabled.
// [RL9] Control B bit 5 doubles half-band output; reset gives unity.
// [RL10] Control A bit 6 picks high-pass response; reset picks low-pass.
// [RL11] Control A bit 1 centres spectrum near eighth rate; else I/Q.
`timescale 1ns/100ps
`default_nettype none
module ddq_ctrl
   import ddq_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_ce,
   // APB
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [9:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   // Quadrature sample stream in
   input wire logic i_q_valid,
   output logic o_q_ready,
   input wire logic [DDQ_SW-1:0] i_q_data,
   // Decimated stream out
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [DDQ_SW-1:0] o_out_data,
   // Control to the down-converter datapath
   output logic o_first_downconverter_enable,
   output logic o_second_downconverter_enable,
   output logic o_oscillator_enable,
   output logic o_dither_generator_enable,
   output logic o_amplitude_dither_enable,
   output logic o_phase_dither_enable,
   output logic o_eighth_rate_centering_enable,
   output logic o_halfband_response_select,
   output logic o_halfband_gain_select,
   output logic [3:0] o_quad_stage_count
);
   ////////////////////////////////////////////////////////////////////////////
   // Functions
   // Count contiguous ones from bit 1 upward when bit 0 is set; bit 0 alone enables nothing
   function automatic logic [3:0] therm_stages(input logic [7:0] f);
      logic [3:0] n;
      n = 4'h0;
      if (f[0]) begin
         for (int k = 1; k < DDQ_NSTG; k++) begin
            if (f[k] && (n == 4'(k - 1))) n = 4'(k);
         end
         if (n == 4'(DDQ_NSTG - 1)) n = 4'(DDQ_NSTG);
         else if (n != 4'h0) n = n + 4'h1;
         n = (n == 4'h0) ? 4'h0 : n - 4'h1;
      end
      return n;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] qdec_r;
   logic [7:0] ctla_r;
   logic [7:0] ctlb_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;

   // Access decode
   wire logic acc = i_psel && i_penable && !pready_r;
   // Byte address is the word index times four
   wire logic hit_qdec = (i_paddr == {DDQ_QDEC_ADDR, DDQ_BYTE_LANE});
   wire logic hit_ctla = (i_paddr == {DDQ_CTLA_ADDR, DDQ_BYTE_LANE});
   wire logic hit_ctlb = (i_paddr == {DDQ_CTLB_ADDR, DDQ_BYTE_LANE});
   wire logic hit_stat = (i_paddr == {DDQ_STAT_ADDR, DDQ_BYTE_LANE});
   wire logic mapped = hit_qdec || hit_ctla || hit_ctlb || hit_stat;
   wire logic wr = acc && i_pwrite;

   // Decimation settings derived from the field
   wire logic [3:0] stages = therm_stages(qdec_r); // see [RL1] [RL3] [RL4]
   wire logic ddc_mode = ctla_r[DDQ_A_DDC1] && ctla_r[DDQ_A_LFSR]
      && ctla_r[DDQ_A_OSC]; // see [RL7]
   wire logic [3:0] eff_stages = ddc_mode ? stages : 4'h0; // see [RL2]

   // Status word: live stage count, mode and fifo level flags
   logic fifo_in_ready;
   logic fifo_out_valid;
   wire logic [31:0] stat_word = {22'h000000, fifo_out_valid, !fifo_in_ready,
      ddc_mode, 3'h0, eff_stages};

   wire logic [31:0] rd_mux = hit_qdec ? {24'h000000, qdec_r}
      : hit_ctla ? {24'h000000, ctla_r}
      : hit_ctlb ? {24'h000000, ctlb_r}
      : hit_stat ? stat_word : DDQ_ZERO32;

   // APB slave: one wait state, answer in the cycle after the access phase starts
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= DDQ_ZERO32;
      end else if (i_ce) begin
         pready_r <= acc;
         pslverr_r <= acc && !mapped;
         prdata_r <= (acc && !i_pwrite) ? rd_mux : DDQ_ZERO32;
      end
   end

   // Register writes; factory bits stored as written, host keeps them
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         qdec_r <= DDQ_QDEC_RST; // see [RL5]
         ctla_r <= DDQ_CTLA_RST; // see [RL10] [RL11]
         ctlb_r <= DDQ_CTLB_RST; // see [RL8] [RL9]
      end else if (i_ce && wr) begin
         if (hit_qdec) qdec_r <= i_pwdata[7:0];
         if (hit_ctla) ctla_r <= i_pwdata[7:0];
         if (hit_ctlb) ctlb_r <= i_pwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Quadrature decimator: keep one sample of each 2^stages
   ddq_state_t state_r;
   logic [DDQ_CNTW-1:0] cnt_r;
   wire logic [DDQ_CNTW-1:0] ratio = DDQ_CNT_ONE << eff_stages; // see [RL1]
   wire logic take = i_q_valid && o_q_ready;
   wire logic keep = take && (cnt_r == '0);
   wire logic [DDQ_CNTW-1:0] cnt_nxt = (cnt_r == ratio - DDQ_CNT_ONE) ? '0
      : cnt_r + DDQ_CNT_ONE;

   // Stall the source when the fifo is full; only kept samples need room
   assign o_q_ready = (state_r == DDQ_RUN) && (fifo_in_ready || cnt_r != '0);

   // Idle until the first clocked edge after reset, then run
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_r <= DDQ_IDLE;
         cnt_r <= '0;
      end else if (i_ce) begin
         case (state_r)
            DDQ_IDLE: begin
               state_r <= DDQ_RUN;
               cnt_r <= '0;
            end
            DDQ_RUN: begin
               if (take) cnt_r <= cnt_nxt; // see [RL2] [RL4]
            end
            default: begin
               state_r <= DDQ_IDLE;
            end
         endcase
      end
   end

   logic fifo_valid;
   logic [DDQ_SW-1:0] fifo_data;
   ddq_fifo #(
      .WIDTH(DDQ_SW),
      .DEPTH(DDQ_FIFO_DEPTH)
   ) u_fifo (
      .i_mclk(i_mclk),
      .i_reset_n(i_reset_n),
      .i_ce(i_ce),
      .i_in_valid(keep),
      .o_in_ready(fifo_in_ready),
      .i_in_data(i_q_data),
      .o_out_valid(fifo_valid),
      .i_out_ready(!o_out_valid || i_out_ready),
      .o_out_data(fifo_data)
   );
   assign fifo_out_valid = fifo_valid;

   // Output stage register so the stream leaves from flip-flops
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_out_valid <= 1'b0;
         o_out_data <= '0;
      end else if (i_ce) begin
         if (!o_out_valid || i_out_ready) begin
            o_out_valid <= fifo_valid;
            o_out_data <= fifo_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control outputs, registered
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_first_downconverter_enable <= 1'b0;
         o_second_downconverter_enable <= 1'b0;
         o_oscillator_enable <= 1'b0;
         o_dither_generator_enable <= 1'b0;
         o_amplitude_dither_enable <= 1'b0;
         o_phase_dither_enable <= 1'b0;
         o_eighth_rate_centering_enable <= 1'b0;
         o_halfband_response_select <= 1'b0;
         o_halfband_gain_select <= 1'b0;
         o_quad_stage_count <= 4'h0;
      end else if (i_ce) begin
         o_first_downconverter_enable <= ctla_r[DDQ_A_DDC1];
         o_second_downconverter_enable <= ctlb_r[DDQ_B_DDC2]; // see [RL8]
         o_oscillator_enable <= ctla_r[DDQ_A_OSC];
         o_dither_generator_enable <= ctla_r[DDQ_A_LFSR];
         o_amplitude_dither_enable <= ctla_r[DDQ_A_AMPD];
         o_phase_dither_enable <= ctla_r[DDQ_A_PHSD];
         o_eighth_rate_centering_enable <= ctla_r[DDQ_A_FS8]; // see [RL11]
         o_halfband_response_select <= ctla_r[DDQ_A_HBSEL]; // see [RL10]
         o_halfband_gain_select <= ctlb_r[DDQ_B_GAIN]; // see [RL9]
         o_quad_stage_count <= eff_stages; // see [RL2]
      end
   end

   assign o_pready = pready_r;
   assign o_prdata = prdata_r;
   assign o_pslverr = pslverr_r;
endmodule // ddq_ctrl
`default_nettype wire

// ===== verilog/ddq_fifo.sv
// Purpose: Small flip-flop FIFO with valid/ready on both sides
// Assumes: Single clock, clock enable freezes all state
// Notes: Depth must be a power of two
`timescale 1ns/100ps
`default_nettype none
module ddq_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_ce,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wp_r;
   logic [AW:0] rp_r;
   wire logic full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
   wire logic empty = (wp_r == rp_r);
   wire logic push = i_ce && i_in_valid && !full;
   wire logic pop = i_ce && i_out_ready && !empty;
   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = mem_r[rp_r[AW-1:0]];
   // Pointers carry a wrap bit so full and empty stay honest
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + 1'b1;
         if (pop) rp_r <= rp_r + 1'b1;
      end
   end
   // Storage needs no reset
   always_ff @(posedge i_mclk) begin
      if (push) mem_r[wp_r[AW-1:0]] <= i_in_data;
   end
endmodule // ddq_fifo
`default_nettype wire
